// ---- rtl/fdfb_map.svh ----
// Purpose: Constants of the field delay buffer: memory map, block sizes and timing counts.
// Assumes: A 50 MHz system clock; port clocks arrive as sampled level inputs.
// Notes:   Definitions only.
`ifndef FDFB_MAP_SVH
`define FDFB_MAP_SVH

`define FDFB_CLK_MHZ        50
`define FDFB_ADDR_W         19
`define FDFB_DATA_W         8
`define FDFB_SRAM_WORDS     19'h00050
`define FDFB_TOP_ADDR       19'h4004F
`define FDFB_BLK_W          12
`define FDFB_OFF_W          6
`define FDFB_BLK_WORDS      64
`define FDFB_DRAM_BLOCKS    4096
`define FDFB_LAST_OFF        6'h3F
`define FDFB_LAST_BLK       12'hFFF
`define FDFB_XFER_CYC       4'h8
`define FDFB_MIN_NEW_LEAD   200
`define FDFB_MIN_CLEAR_GAP  82
`define FDFB_REFRESH_NS     15600
`define FDFB_REFRESH_CYC    ((`FDFB_REFRESH_NS * `FDFB_CLK_MHZ) / 1000)
`define FDFB_FIFO_DEPTH     4

`endif

// ---- rtl/fdfb_pkg.sv ----
// Purpose: Types shared by the field delay buffer.
// Assumes: fdfb_map.svh is on the include path.
// Notes:   Holds types only; figures live in the map header.
`include "fdfb_map.svh"

package fdfb_pkg;

    typedef logic [`FDFB_ADDR_W-1:0] fdfb_addr_t;
    typedef logic [`FDFB_DATA_W-1:0] fdfb_word_t;
    typedef logic [`FDFB_BLK_WORDS*`FDFB_DATA_W-1:0] fdfb_row_t;

    typedef struct packed {
        fdfb_addr_t addr;
        fdfb_word_t data;
        logic       flush;
    } fdfb_item_s;

    typedef enum logic [1:0] {
        FDFB_IDLE = 2'b01,
        FDFB_XFER = 2'b10
    } fdfb_commit_e;

endpackage : fdfb_pkg

// ---- rtl/fdfb_top.sv ----
// Purpose: Serial field memory used as a FIFO or delay line, with independent fill and drain ports.
// Assumes: Port clocks, clears and gates are synchronous levels sampled on clk.
// Notes:   Low addresses sit in a dual-port SRAM, the rest in 64-word DRAM rows.
//
// Functional notes
// - Drain clear 200 or more cycles after fill clear returns fresh data.
// - Addresses 0 to 79 are SRAM, 80 and upward are DRAM.
// - DRAM goes through data registers; transfers are arbitrated, never conflicting.
// - SRAM writes are unconditional; a clashing read returns the old word.
// - Lead of 1 to 199 gives old DRAM data; SRAM may show new.
// - After a spacing violation, a proper later clear restores normal work.
// - DRAM refresh timer runs on its own, without port clocks.
// - Fill and drain sides initialise independently; earlier data is unguaranteed.
// - Periodic clears in delay-line use satisfy initialisation automatically.
// - Breaking the drain-gate rule at address 0 may skip address 0 or 1.
// - Fill data reaches DRAM as a full 64-word block, or as a partial block on a fill clear or wrap.
// - Drain side prefetches the next 64-word block, staging up to 128 words.
// - New-data lead is 200: 192 buffering cycles plus 8 transfer cycles.
// - First output word appears one clk after the first drain step with the gate asserted.
// - Wrapping from 262,223 to 0 without a clear acts as a clear.
// - A fill clear flushes the fill data register into DRAM.
`timescale 1ns/1ps
`include "fdfb_map.svh"

////////////////////////////////////////////////////////////////////////////////

module fdfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output      logic             in_ready,
    output      logic [WIDTH-1:0] out_data,
    output      logic             out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

endmodule : fdfb_fifo

////////////////////////////////////////////////////////////////////////////////

module fdfb_top (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    fill_clock,
    input  wire logic                    fill_pointer_clear_n,
    input  wire logic                    fill_gate_n,
    input  wire logic [`FDFB_DATA_W-1:0] sample_in,
    output      logic                    fill_ready,
    input  wire logic                    drain_clock,
    input  wire logic                    drain_pointer_clear_n,
    input  wire logic                    drain_gate_n,
    output      logic [`FDFB_DATA_W-1:0] sample_out,
    output      logic                    sample_valid
);
    localparam int IW = $bits(fdfb_pkg::fdfb_item_s);
    localparam logic [9:0] REFRESH_LAST = 10'(`FDFB_REFRESH_CYC - 1);

    // Storage: SRAM words, DRAM rows of one block each.
    fdfb_pkg::fdfb_word_t sram [`FDFB_SRAM_WORDS];
    fdfb_pkg::fdfb_row_t  dram [`FDFB_DRAM_BLOCKS];

    ////////////////////////////////////////////////////////////////////////////
    // Fill port: edge detection, pointer and hand-off into the FIFO.

    logic                 fill_clock_q;
    fdfb_pkg::fdfb_addr_t fill_ptr;
    fdfb_pkg::fdfb_item_s fill_item;
    fdfb_pkg::fdfb_item_s pop_item;
    logic [IW-1:0]        pop_bits;
    logic                 fifo_in_ready;
    logic                 pop_valid;
    logic                 pop_ready;

    wire fill_edge  = fill_clock & ~fill_clock_q;
    wire fill_clear = ~fill_pointer_clear_n;
    wire fill_wrap  = (fill_ptr == `FDFB_TOP_ADDR);
    wire fill_push  = fill_edge & fifo_in_ready & (fill_clear | ~fill_gate_n);
    wire fill_step  = fill_edge & fifo_in_ready;

    // A clear step writes address 0 on that same step.
    wire fdfb_pkg::fdfb_addr_t fill_addr = fill_clear ? '0 : fill_ptr;
    wire fdfb_pkg::fdfb_addr_t next_fill_ptr =
        (fill_wrap & ~fill_clear) ? '0 : fill_addr + 1'b1;

    assign fill_item.addr  = fill_addr;
    assign fill_item.data  = sample_in;
    assign fill_item.flush = fill_clear | fill_wrap;
    assign pop_item        = fdfb_pkg::fdfb_item_s'(pop_bits);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_clock_q <= 1'b0;
            fill_ptr     <= '0;
            fill_ready   <= 1'b0;
        end else begin
            fill_clock_q <= fill_clock;
            fill_ready   <= fifo_in_ready;
            if (fill_step & (fill_clear | ~fill_gate_n)) begin
                fill_ptr <= ~fill_gate_n ? next_fill_ptr : fill_addr;
            end
        end
    end

    fdfb_fifo #(
        .WIDTH (IW),
        .DEPTH (`FDFB_FIFO_DEPTH)
    ) u_fill_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (fill_item),
        .in_valid  (fill_push),
        .in_ready  (fifo_in_ready),
        .out_data  (pop_bits),
        .out_valid (pop_valid),
        .out_ready (pop_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fill engine: SRAM writes, fill data register and block commit.

    fdfb_pkg::fdfb_commit_e      cstate;
    fdfb_pkg::fdfb_row_t         wreg;
    fdfb_pkg::fdfb_row_t         next_wreg;
    fdfb_pkg::fdfb_row_t         commit_row;
    logic [`FDFB_BLK_W-1:0]      wblk;
    logic [`FDFB_BLK_W-1:0]      commit_blk;
    logic                        wdirty;
    logic [3:0]                  xfer_cnt;
    logic [9:0]                  refresh_cnt;

    wire pop        = pop_valid & pop_ready;
    wire pop_sram   = (pop_item.addr < `FDFB_SRAM_WORDS);
    wire fdfb_pkg::fdfb_addr_t pop_doff = pop_item.addr - `FDFB_SRAM_WORDS;
    wire [`FDFB_BLK_W-1:0] pop_blk = pop_doff[`FDFB_OFF_W +: `FDFB_BLK_W];
    wire [`FDFB_OFF_W-1:0] pop_off = pop_doff[`FDFB_OFF_W-1:0];
    wire pop_dram   = pop & ~pop_sram;
    wire blk_full   = pop_dram & (pop_off == `FDFB_LAST_OFF);
    wire blk_flush  = pop & pop_item.flush & wdirty;
    wire commit_go  = blk_full | blk_flush;
    wire refresh    = (refresh_cnt == REFRESH_LAST);
    wire xfer_done  = (cstate == fdfb_pkg::FDFB_XFER) & ~refresh &
                      (xfer_cnt == `FDFB_XFER_CYC - 4'h1);

    // The engine pauses during a transfer; the FIFO then backs up to the fill port.
    assign pop_ready = (cstate == fdfb_pkg::FDFB_IDLE);

    always_comb begin
        next_wreg = wreg;
        if (pop_dram) begin
            next_wreg[{pop_off, 3'b000} +: `FDFB_DATA_W] = pop_item.data;
        end
    end

    // Unconditional SRAM write; a drain read of the same word this cycle sees the old word.
    always_ff @(posedge clk) begin
        if (pop & pop_sram) begin
            sram[pop_item.addr[6:0]] <= pop_item.data;
        end
        if (xfer_done) begin
            dram[commit_blk] <= commit_row;
        end
    end

    always_ff @(posedge clk) begin
        wreg <= next_wreg;
        if (commit_go) begin
            commit_row <= blk_full ? next_wreg : wreg;
            commit_blk <= blk_full ? pop_blk : wblk;
        end
    end

    // Refresh runs from clk alone, regardless of either port clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refresh_cnt <= '0;
        end else begin
            refresh_cnt <= refresh ? '0 : refresh_cnt + 10'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cstate   <= fdfb_pkg::FDFB_IDLE;
            xfer_cnt <= '0;
            wblk     <= '0;
            wdirty   <= 1'b0;
        end else begin
            if (pop_dram) begin
                wblk   <= pop_blk;
                wdirty <= ~blk_full;
            end else if (blk_flush) begin
                wdirty <= 1'b0;
            end
            unique case (cstate)
                fdfb_pkg::FDFB_IDLE: begin
                    xfer_cnt <= '0;
                    if (commit_go) begin
                        cstate <= fdfb_pkg::FDFB_XFER;
                    end
                end
                fdfb_pkg::FDFB_XFER: begin
                    if (xfer_done) begin
                        cstate <= fdfb_pkg::FDFB_IDLE;
                    end else if (~refresh) begin
                        xfer_cnt <= xfer_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drain port: pointer, read data registers with prefetch, output word.

    logic                 drain_clock_q;
    fdfb_pkg::fdfb_addr_t drain_ptr;
    fdfb_pkg::fdfb_row_t  rcur;
    fdfb_pkg::fdfb_row_t  rnxt;

    wire drain_edge  = drain_clock & ~drain_clock_q;
    wire drain_clear = ~drain_pointer_clear_n;
    wire drain_wrap  = (drain_ptr == `FDFB_TOP_ADDR);
    wire drain_step  = drain_edge & ~drain_gate_n;
    wire fdfb_pkg::fdfb_addr_t drain_addr = drain_clear ? '0 : drain_ptr;
    wire fdfb_pkg::fdfb_addr_t next_drain_ptr =
        (drain_wrap & ~drain_clear) ? '0 : drain_addr + 1'b1;
    wire drain_sram  = (drain_addr < `FDFB_SRAM_WORDS);
    wire fdfb_pkg::fdfb_addr_t drain_doff = drain_addr - `FDFB_SRAM_WORDS;
    wire [`FDFB_BLK_W-1:0] drain_blk = drain_doff[`FDFB_OFF_W +: `FDFB_BLK_W];
    wire [`FDFB_OFF_W-1:0] drain_off = drain_doff[`FDFB_OFF_W-1:0];
    wire drain_enter = drain_step & ~drain_sram & (drain_off == '0);
    wire drain_rearm = drain_step & (drain_clear | drain_wrap);
    wire [`FDFB_BLK_W-1:0] pre_blk =
        (drain_blk == `FDFB_LAST_BLK) ? '0 : drain_blk + 1'b1;
    wire fdfb_pkg::fdfb_row_t drain_row = drain_enter ? rnxt : rcur;
    wire fdfb_pkg::fdfb_word_t drain_word =
        drain_sram ? sram[drain_addr[6:0]] :
                     drain_row[{drain_off, 3'b000} +: `FDFB_DATA_W];

    always_ff @(posedge clk) begin
        if (drain_rearm) begin
            rnxt <= dram['0];
        end else if (drain_enter) begin
            rcur <= rnxt;
            rnxt <= dram[pre_blk];
        end
    end

    // Output is registered: the word shows the cycle after the step that reads it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drain_clock_q <= 1'b0;
            drain_ptr     <= '0;
            sample_out    <= '0;
            sample_valid  <= 1'b0;
        end else begin
            drain_clock_q <= drain_clock;
            sample_valid  <= drain_step;
            if (drain_step) begin
                drain_ptr  <= next_drain_ptr;
                sample_out <= drain_word;
            end
        end
    end

endmodule : fdfb_top

// ---- tb/fdfb_top_assertions.sv ----
// Purpose: Port-level checks of the field delay buffer.
// Assumes: Port clocks are levels sampled on clk; a step is a seen rise.
// Notes:   Helper flops rebuild the step detect the design uses.
`timescale 1ns/1ps
`include "fdfb_map.svh"

////////////////////////////////////////////////////////////////////////////////

module fdfb_top_chk (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    fill_clock,
    input wire logic                    fill_pointer_clear_n,
    input wire logic                    fill_gate_n,
    input wire logic [`FDFB_DATA_W-1:0] sample_in,
    input wire logic                    fill_ready,
    input wire logic                    drain_clock,
    input wire logic                    drain_pointer_clear_n,
    input wire logic                    drain_gate_n,
    input wire logic [`FDFB_DATA_W-1:0] sample_out,
    input wire logic                    sample_valid
);
    logic fprev;
    logic dprev;
    logic fstep;
    logic dstep;
    logic dskip;
    assign fstep = fill_clock & ~fprev;
    assign dstep = drain_clock & ~dprev & ~drain_gate_n;
    assign dskip = drain_clock & ~dprev & drain_gate_n;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fprev <= 1'b0;
            dprev <= 1'b0;
        end else begin
            fprev <= fill_clock;
            dprev <= drain_clock;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    step_answer_a: assert property (dstep |=> sample_valid)
        else $error("drain step got no answer");
    answer_cause_a: assert property (sample_valid |-> $past(dstep))
        else $error("answer without a drain step");
    gate_block_a: assert property (dskip |=> !sample_valid)
        else $error("gated drain step answered");
    valid_pulse_a: assert property (sample_valid |=> !sample_valid)
        else $error("answer pulse too long");
    out_hold_a: assert property ($changed(sample_out) |-> sample_valid)
        else $error("output word moved between steps");
    reset_state_a: assert property ($fell(rst) |-> !fill_ready && !sample_valid
        && sample_out == 8'h00 ##1 fill_ready)
        else $error("bad state around reset release");
    ready_cause_a: assert property ($fell(fill_ready) |->
        $past(fstep) || $past(fstep, 2) || $past(fstep, 3))
        else $error("fill side stalled without a fill step");
    ready_return_a: assert property (!fill_ready |-> ##[1:60] fill_ready)
        else $error("fill side stalled too long");
endmodule : fdfb_top_chk

bind fdfb_top fdfb_top_chk u_chk (
    .clk(clk), .rst(rst), .fill_clock(fill_clock),
    .fill_pointer_clear_n(fill_pointer_clear_n), .fill_gate_n(fill_gate_n),
    .sample_in(sample_in), .fill_ready(fill_ready), .drain_clock(drain_clock),
    .drain_pointer_clear_n(drain_pointer_clear_n), .drain_gate_n(drain_gate_n),
    .sample_out(sample_out), .sample_valid(sample_valid)
);

// ---- tb/fdfb_video_src.sv ----
// Purpose: Video sampling logic that drives both ports of the buffer.
// Assumes: One call of step is one common sampling clock period.
// Notes:   Fill data is inverted once the step has been taken.
`timescale 1ns/1ps
`include "fdfb_map.svh"

////////////////////////////////////////////////////////////////////////////////

module fdfb_video_src (
    input  wire logic                    clk,
    input  wire logic                    fill_ready,
    input  wire logic                    sample_valid,
    input  wire logic [`FDFB_DATA_W-1:0] sample_out,
    output      logic                    fill_clock,
    output      logic                    fill_pointer_clear_n,
    output      logic                    fill_gate_n,
    output      logic [`FDFB_DATA_W-1:0] sample_in,
    output      logic                    drain_clock,
    output      logic                    drain_pointer_clear_n,
    output      logic                    drain_gate_n,
    output      logic                    starved
);
    initial begin
        {fill_clock, drain_clock, starved} = 3'b000;
        {fill_pointer_clear_n, fill_gate_n} = 2'b11;
        {drain_pointer_clear_n, drain_gate_n} = 2'b11;
        sample_in = 8'h00;
    end
    task automatic step(input logic fg, fc, dg, dc, input logic [7:0] d,
                        output logic rv, output logic [7:0] rd);
        int i;
        @(posedge clk);
        for (i = 0; i < 60 && fill_ready !== 1'b1; i++) @(posedge clk);
        if (fill_ready !== 1'b1) starved <= 1'b1;
        fill_clock <= 1'b1;
        drain_clock <= 1'b1;
        {fill_gate_n, fill_pointer_clear_n, sample_in} <= {fg, fc, d};
        {drain_gate_n, drain_pointer_clear_n} <= {dg, dc};
        @(posedge clk);
        {fill_clock, drain_clock} <= 2'b00;
        sample_in <= ~d;
        // The answer pulse stands for one cycle only, so it is taken right after the step.
        #1;
        rv = sample_valid;
        rd = sample_out;
        @(posedge clk);
    endtask : step
endmodule : fdfb_video_src

// ---- tb/field_delay_fifo_buffer_tb.sv ----
// Purpose: Self-checking bench of the field delay buffer.
// Assumes: Fifty megahertz clock; the source model paces both ports.
// Notes:   Each run writes a salted pattern and reads back, delayed, either that pattern or the previous run's.
`timescale 1ns/1ps
`include "fdfb_map.svh"

////////////////////////////////////////////////////////////////////////////////

module field_delay_fifo_buffer_tb;
    logic                    clk;
    logic                    rst;
    logic                    fill_clock;
    logic                    fill_pointer_clear_n;
    logic                    fill_gate_n;
    logic [`FDFB_DATA_W-1:0] sample_in;
    logic                    fill_ready;
    logic                    drain_clock;
    logic                    drain_pointer_clear_n;
    logic                    drain_gate_n;
    logic [`FDFB_DATA_W-1:0] sample_out;
    logic                    sample_valid;
    logic                    starved;
    int                      bad_count = 0;
    int                      cmp_count = 0;

    fdfb_top u_dut (
        .clk(clk), .rst(rst), .fill_clock(fill_clock),
        .fill_pointer_clear_n(fill_pointer_clear_n), .fill_gate_n(fill_gate_n),
        .sample_in(sample_in), .fill_ready(fill_ready), .drain_clock(drain_clock),
        .drain_pointer_clear_n(drain_pointer_clear_n), .drain_gate_n(drain_gate_n),
        .sample_out(sample_out), .sample_valid(sample_valid));
    fdfb_video_src u_src (
        .clk(clk), .fill_ready(fill_ready), .sample_valid(sample_valid),
        .sample_out(sample_out), .fill_clock(fill_clock), .sample_in(sample_in),
        .fill_pointer_clear_n(fill_pointer_clear_n), .fill_gate_n(fill_gate_n),
        .drain_clock(drain_clock), .drain_pointer_clear_n(drain_pointer_clear_n),
        .drain_gate_n(drain_gate_n), .starved(starved));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] pat(int a, int s);
        return 8'(a * 3 + s * 29);
    endfunction : pat

    task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Fill runs from step 0 up to fl, then a gated-off clear flushes the row.
    task automatic run_delay(int lead, int fl, int n, int salt, int es, int lo);
        int s;
        logic rv;
        logic [7:0] rd;
        for (s = 0; s < lead + n; s++) begin
            u_src.step(s >= fl, !(s == 0 || s == fl), s < lead, s != lead,
                       pat((s == fl) ? 0 : s, salt), rv, rd);
            if (s < lead) check("idle_valid", 8'h00, {7'h00, rv});
            else if (s - lead >= lo) begin
                check("valid", 8'h01, {7'h00, rv});
                check("word", pat(s - lead, es), rd);
            end
        end
    endtask : run_delay

    task automatic sc_reset();
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("rst_valid", 8'h00, {7'h00, sample_valid});
        check("rst_out", 8'h00, sample_out);
        check("rst_ready", 8'h00, {7'h00, fill_ready});
        @(posedge clk) rst <= 1'b0;
        @(posedge clk);
        #1;
        check("ready", 8'h01, {7'h00, fill_ready});
    endtask : sc_reset

    task automatic sc_init();
        int k;
        logic rv;
        logic [7:0] rd;
        for (k = 0; k < `FDFB_MIN_CLEAR_GAP; k++) begin
            u_src.step(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, rv, rd);
            check("dummy_valid", 8'h00, {7'h00, rv});
        end
    endtask : sc_init

    task automatic sc_flush();
        int k;
        logic rv;
        logic [7:0] rd;
        for (k = 0; k < 4; k++) u_src.step(1'b1, k == 3, 1'b0, k == 3, 8'h00, rv, rd);
        run_delay(100, 90, 90, 4, 4, 0);
    endtask : sc_flush

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("unexpected timeout expected 0 seen 1");
        wrap_up();
    end

    initial begin
        sc_reset();
        sc_init();
        run_delay(200, 350, 150, 1, 1, 0);
        run_delay(0, 150, 150, 2, 1, 0);
        run_delay(100, 200, 100, 3, 2, 80);
        sc_flush();
        check("starved", 8'h00, {7'h00, starved});
        wrap_up();
    end
endmodule : field_delay_fifo_buffer_tb
